// ===== rtl/vcode_slew_defs.svh
// constants for the voltage code slew controller
`ifndef VCODE_SLEW_DEFS_SVH
`define VCODE_SLEW_DEFS_SVH
`define VCODE_MAX            8'hFF
`define VCODE_STEP_MV        10
`define REG_SLOW_SLEW_RATE   8'h25
`define REG_OUTPUT_OFFSET    8'h33
`define SLOW_RATE_RESET      8'h01
`define OFFSET_RESET         8'h00
`define STEP_CLK_MHZ         4
`define CLOCK_MHZ            125
`define STEP_DIV_CYCLES      ((`CLOCK_MHZ + `STEP_CLK_MHZ - 1) / `STEP_CLK_MHZ)
`define READY_MASK_US        2
`define READY_MASK_CYCLES    (`READY_MASK_US * `CLOCK_MHZ)
`endif

// ===== rtl/vcode_slew_pkg.sv
// types for the voltage code slew controller
package vcode_slew_pkg;
  typedef enum logic [1:0] {
    cmd_none_type_e,
    cmd_fast_e,
    cmd_slow_e,
    cmd_decay_e
  } cmd_kind_type;
  typedef enum {
    st_idle,
    st_ramp,
    st_decay
  } slew_state_type;
endpackage

// ===== rtl/step_tick_if.sv
// stepping tick carrier between controller and tick generator
`timescale 1ns/10ps
interface step_tick_if;
  logic       tick;
  logic [7:0] divide;
  modport gen  (output tick, input divide);
  modport user (input tick, output divide);
endinterface

// ===== rtl/step_tick_gen.sv
// stepping clock tick generator
`timescale 1ns/10ps
`include "vcode_slew_defs.svh"
module step_tick_gen (
  input wire logic    clock,
  input wire logic    resetn,
  step_tick_if.gen    tk
);
  logic [15:0] cnt_q;
  logic [15:0] limit;
  assign limit = 16'(`STEP_DIV_CYCLES) * {8'h00, tk.divide};
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q + 16'h0001 >= limit) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  assign tk.tick = (cnt_q + 16'h0001 >= limit);
endmodule // step_tick_gen

// ===== rtl/voltage_code_slew_controller.sv
// voltage code slew controller top
`timescale 1ns/10ps
`include "vcode_slew_defs.svh"
module voltage_code_slew_controller #(
  parameter int MASK_CYCLES = `READY_MASK_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_kind,
  input  wire logic [7:0] cmd_code,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       power_cmd_valid,
  input  wire logic       power_cmd_low,
  input  wire logic       transition_settled,
  output logic            cmd_accept,
  output logic            cmd_reject,
  output logic [7:0]      reg_rdata,
  output logic [7:0]      reference_code,
  output logic [7:0]      target_code,
  output logic            busy,
  output logic            full_power_state,
  output logic            all_phases_active,
  output logic            ready_mask,
  output logic            regulator_ready
);
  vcode_slew_pkg::slew_state_type state_q;
  step_tick_if tk ();
  logic [7:0]  slow_rate_q;
  logic [7:0]  offset_q;
  logic [7:0]  vcode_q;
  logic [7:0]  ref_q;
  logic [7:0]  tgt_q;
  logic        use_slow_q;
  logic        fullp_q;
  logic [2:0]  settle_sync_q;
  logic        settle_prev_q;
  logic [31:0] mask_q;
  logic [8:0]  off_sum;
  logic        offset_cmd;
  logic        offset_ok;
  logic        vset_cmd;
  logic        settle_rise;
  logic        step_now;
  logic        ref_moves;

  step_tick_gen u_tick (
    .clock  (clock),
    .resetn (resetn),
    .tk     (tk)
  );
  assign tk.divide = use_slow_q ? slow_rate_q : 8'h01;

  assign busy       = (state_q != vcode_slew_pkg::st_idle);
  assign offset_cmd = reg_write && (reg_addr == `REG_OUTPUT_OFFSET);
  assign off_sum    = {1'b0, vcode_q} + {1'b0, reg_wdata};
  assign offset_ok  = (off_sum <= {1'b0, `VCODE_MAX});
  assign vset_cmd   = cmd_valid && (cmd_kind != 2'b00);
  // every command taken while idle except a lone bad offset is acknowledged; a bad offset beside a voltage set is dropped
  assign cmd_accept = !busy && (vset_cmd || power_cmd_valid
                      || (reg_write && !(offset_cmd && !offset_ok)));
  assign cmd_reject = (busy && (vset_cmd || reg_write || power_cmd_valid))
                      || (!busy && !vset_cmd && offset_cmd && !offset_ok);

  // settled input from outside: three stage synchroniser
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      settle_sync_q <= 3'b000;
      settle_prev_q <= 1'b0;
    end else begin
      settle_sync_q <= {settle_sync_q[1:0], transition_settled};
      if (settle_sync_q[2] == settle_sync_q[1]) begin
        settle_prev_q <= settle_sync_q[2];
      end
    end
  end
  assign settle_rise = (settle_sync_q[2] == settle_sync_q[1]) && settle_sync_q[2]
                       && !settle_prev_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      slow_rate_q <= `SLOW_RATE_RESET;
      offset_q    <= `OFFSET_RESET;
    end else if (reg_write && !busy) begin
      if (reg_addr == `REG_SLOW_SLEW_RATE) begin
        slow_rate_q <= (reg_wdata == 8'h00) ? 8'h01 : reg_wdata;
      end else if (offset_cmd && offset_ok && !vset_cmd) begin
        offset_q <= reg_wdata;
      end
    end
  end

  always_comb begin
    case (reg_addr)
      `REG_SLOW_SLEW_RATE: reg_rdata = slow_rate_q;
      `REG_OUTPUT_OFFSET:  reg_rdata = offset_q;
      default:             reg_rdata = 8'h00;
    endcase
  end

  assign step_now = (state_q == vcode_slew_pkg::st_ramp) ? tk.tick : settle_rise;
  assign ref_moves = busy && step_now && (ref_q != tgt_q);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q    <= vcode_slew_pkg::st_idle;
      vcode_q    <= 8'h00;
      tgt_q      <= 8'h00;
      ref_q      <= 8'h00;
      use_slow_q <= 1'b0;
    end else begin
      case (state_q)
        vcode_slew_pkg::st_idle: begin
          if (vset_cmd) begin
            vcode_q    <= cmd_code;
            tgt_q      <= 8'(cmd_code + offset_q);
            use_slow_q <= (cmd_kind != 2'b01);
            state_q    <= (cmd_kind == 2'b11) ? vcode_slew_pkg::st_decay
                                              : vcode_slew_pkg::st_ramp;
          end else if (offset_cmd && offset_ok) begin
            tgt_q      <= off_sum[7:0];
            use_slow_q <= 1'b1;
            state_q    <= vcode_slew_pkg::st_ramp;
          end
        end
        vcode_slew_pkg::st_ramp, vcode_slew_pkg::st_decay: begin
          if (ref_q == tgt_q) begin
            state_q <= vcode_slew_pkg::st_idle;
          end else if (step_now) begin
            ref_q <= (ref_q < tgt_q) ? ref_q + 8'h01 : ref_q - 8'h01;
          end
        end
        default: state_q <= vcode_slew_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fullp_q <= 1'b1;
    end else if (!busy && vset_cmd && cmd_kind != 2'b11) begin
      fullp_q <= 1'b1;
    end else if (!busy && vset_cmd) begin
      fullp_q <= 1'b0;
    end else if (power_cmd_valid && !busy) begin
      fullp_q <= !power_cmd_low;
    end
  end
  assign full_power_state  = fullp_q || (state_q == vcode_slew_pkg::st_ramp);
  assign all_phases_active = full_power_state;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mask_q <= 32'h0000_0000;
    end else if (ref_moves) begin
      mask_q <= 32'(MASK_CYCLES);
    end else if (mask_q != 32'h0000_0000) begin
      mask_q <= mask_q - 32'h0000_0001;
    end
  end
  assign ready_mask      = (mask_q != 32'h0000_0000) || busy;
  assign regulator_ready = !ready_mask;
  assign reference_code  = ref_q;
  assign target_code     = tgt_q;

  a_reject_busy: assert property (@(posedge clock) disable iff (!resetn)
    busy && cmd_valid && cmd_kind != 2'b00 |-> cmd_reject && !cmd_accept)
    else $error("command accepted while busy");
  a_power_busy: assert property (@(posedge clock) disable iff (!resetn)
    busy && power_cmd_valid |-> cmd_reject && !cmd_accept)
    else $error("power command accepted while busy");
  a_offset_bad: assert property (@(posedge clock) disable iff (!resetn)
    !busy && offset_cmd && !offset_ok |=> $stable(offset_q))
    else $error("bad offset stored");
  a_offset_good: assert property (@(posedge clock) disable iff (!resetn)
    !busy && !vset_cmd && offset_cmd && offset_ok
    |=> offset_q == $past(reg_wdata) && use_slow_q)
    else $error("offset not stored");
  a_mode_ramp: assert property (@(posedge clock) disable iff (!resetn)
    !busy && vset_cmd && cmd_kind != 2'b11 |=> state_q == vcode_slew_pkg::st_ramp)
    else $error("ramped command did not start a ramp");
  a_mode_decay: assert property (@(posedge clock) disable iff (!resetn)
    !busy && vset_cmd && cmd_kind == 2'b11 |=> state_q == vcode_slew_pkg::st_decay)
    else $error("unslewed command did not start a decay");
  a_step_one: assert property (@(posedge clock) disable iff (!resetn)
    ref_q != $past(ref_q) |-> (ref_q - $past(ref_q) == 8'h01) || ($past(ref_q) - ref_q == 8'h01))
    else $error("step larger than one code");
  a_decay_free: assert property (@(posedge clock) disable iff (!resetn)
    state_q == vcode_slew_pkg::st_decay && !settle_rise |=> $stable(ref_q))
    else $error("decay stepped without a settle edge");
  a_mask: assert property (@(posedge clock) disable iff (!resetn)
    ref_moves |=> mask_q == 32'(MASK_CYCLES) && !regulator_ready)
    else $error("mask not restarted");
  a_full: assert property (@(posedge clock) disable iff (!resetn)
    state_q == vcode_slew_pkg::st_ramp |-> full_power_state && all_phases_active)
    else $error("not full power during ramp");
  a_leave_low: assert property (@(posedge clock) disable iff (!resetn)
    !busy && vset_cmd && cmd_kind != 2'b11 |=> fullp_q [*2])
    else $error("low power kept");
  a_hold_full: assert property (@(posedge clock) disable iff (!resetn)
    fullp_q && !power_cmd_valid && !vset_cmd |=> fullp_q)
    else $error("full power left without a command");
  a_decay_low: assert property (@(posedge clock) disable iff (!resetn)
    state_q == vcode_slew_pkg::st_decay |-> !full_power_state)
    else $error("full power during decay");
  a_decay_step: assert property (@(posedge clock) disable iff (!resetn)
    state_q == vcode_slew_pkg::st_decay && ref_q != $past(ref_q) |-> $past(settle_rise))
    else $error("decay step without settle");
  a_done: assert property (@(posedge clock) disable iff (!resetn)
    busy && ref_q == tgt_q |=> !busy)
    else $error("stays busy at target");
endmodule // voltage_code_slew_controller

// ===== verif/settle_source.sv
// far-side model of the settle indication
`timescale 1ns/10ps
module settle_source (
  input  wire logic run,
  output logic      transition_settled
);
  initial begin
    transition_settled = 1'b0;
    forever begin
      #32;
      // one rising edge per 64 ns while a decay runs, low otherwise
      transition_settled = run ? ~transition_settled : 1'b0;
    end
  end
endmodule // settle_source

// ===== verif/voltage_code_slew_controller_tb_top.sv
// self-checking bench for the voltage code slew controller
`timescale 1ns/10ps
module voltage_code_slew_controller_tb_top;
  logic       clock, resetn, cmd_valid, reg_write, power_cmd_valid;
  logic       power_cmd_low, transition_settled, run, cmd_accept, cmd_reject;
  logic       busy, full_power_state, all_phases_active, ready_mask, regulator_ready;
  logic [1:0] cmd_kind;
  logic [7:0] cmd_code, reg_addr, reg_wdata, reg_rdata, reference_code, target_code;
  int         failures = 0;
  int         checked = 0;
  int         n;
  voltage_code_slew_controller #(.MASK_CYCLES(10)) i_dut (
    .clock, .resetn, .cmd_valid, .cmd_kind, .cmd_code, .reg_write, .reg_addr,
    .reg_wdata, .power_cmd_valid, .power_cmd_low, .transition_settled,
    .cmd_accept, .cmd_reject, .reg_rdata, .reference_code, .target_code, .busy,
    .full_power_state, .all_phases_active, .ready_mask, .regulator_ready);
  settle_source i_settle (.run, .transition_settled);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // s: bit0 voltage set, bit1 register write, bit2 power; e: {reject, accept}
  task automatic send(input logic [2:0] s, input logic [7:0] x, y, input logic [1:0] e);
    @(posedge clock);
    cmd_valid <= s[0];
    reg_write <= s[1];
    power_cmd_valid <= s[2];
    cmd_kind <= x[1:0];
    reg_addr <= x;
    cmd_code <= y;
    reg_wdata <= y;
    power_cmd_low <= y[0];
    @(negedge clock);
    if (e != 2'h0) chk("answer", {6'h00, e}, {6'h00, cmd_reject, cmd_accept});
    @(posedge clock);
    cmd_valid <= 1'b0;
    reg_write <= 1'b0;
    power_cmd_valid <= 1'b0;
    @(negedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    @(negedge clock);
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic idle();
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    if (busy !== 1'b0) begin
      failures++;
      $display("[FAIL] busy expected 0 seen %b", busy);
    end
  endtask
  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    conclude();
  end
  initial begin
    {resetn, cmd_valid, reg_write, power_cmd_valid, power_cmd_low, run} = 6'h00;
    {cmd_kind, cmd_code, reg_addr, reg_wdata} = 26'h0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    chk("reference", 8'h00, reference_code);
    chk("full power", 8'h01, {7'h00, full_power_state});
    rd(8'h25, 8'h01);
    rd(8'h33, 8'h00);
    rd(8'h40, 8'h00);
    send(3'h1, 8'h01, 8'h04, 2'h1);
    chk("flags", 8'h0E, {4'h0, busy, full_power_state, all_phases_active, regulator_ready});
    chk("ready mask", 8'h01, {7'h00, ready_mask});
    send(3'h1, 8'h02, 8'h07, 2'h2);
    idle();
    chk("fast span", 8'h01, {7'h00, n > 90 && n < 134});
    chk("reference", 8'h04, reference_code);
    send(3'h2, 8'h25, 8'h02, 2'h1);
    rd(8'h25, 8'h02);
    send(3'h2, 8'h33, 8'h03, 2'h1);
    chk("target", 8'h07, target_code);
    send(3'h2, 8'h33, 8'h01, 2'h2);
    idle();
    chk("slow span", 8'h01, {7'h00, n > 110 && n < 200});
    chk("reference", 8'h07, reference_code);
    send(3'h2, 8'h33, 8'hFC, 2'h2);
    rd(8'h33, 8'h03);
    repeat (12) @(negedge clock);
    chk("ready", 8'h01, {7'h00, regulator_ready});
    chk("ready mask", 8'h00, {7'h00, ready_mask});
    chk("full power", 8'h01, {7'h00, full_power_state});
    send(3'h4, 8'h00, 8'h01, 2'h1);
    chk("full power", 8'h00, {7'h00, full_power_state});
    send(3'h1, 8'h02, 8'h02, 2'h1);
    chk("flags", 8'h0E, {4'h0, busy, full_power_state, all_phases_active, regulator_ready});
    send(3'h4, 8'h00, 8'h01, 2'h2);
    idle();
    chk("reference", 8'h05, reference_code);
    chk("full power", 8'h01, {7'h00, full_power_state});
    send(3'h1, 8'h03, 8'h00, 2'h1);
    chk("full power", 8'h00, {7'h00, full_power_state});
    repeat (40) @(negedge clock);
    chk("reference", 8'h05, reference_code);
    run = 1'b1;
    idle();
    run = 1'b0;
    chk("reference", 8'h03, reference_code);
    conclude();
  end
endmodule // voltage_code_slew_controller_tb_top
